/* File: cic_core.sv */
// core interrupt control block with apb register slave
//
// Our own choices: register access over APB and the register offsets.
module cic_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0Overflow,
  input wire logic extInt0Pin,
  input wire logic [3:0] upperPortBPins,
  output logic irqHigh,
  output logic irqLow,
  output logic irq
);
  import cic_pkg::*;

  logic [7:0] intCtl_q;
  logic pFlag1_q;
  logic pEn1_q;
  logic [2:0] prio_q;
  logic [3:0] portbLatch_q;
  logic [CIC_NEVT-1:0] iStat_q;
  logic [CIC_NEVT-1:0] iMask_q;
  logic int0Prev_q;
  logic [31:0] prdata_q;
  logic [3:0] rbSync;
  logic int0Sync;
  logic [15:0] t1Count;
  logic t1Wrap;

  cic_sync #(.W(5)) uSync (
    .clk(clk),
    .rst(rst),
    .din({extInt0Pin, upperPortBPins}),
    .dout({int0Sync, rbSync})
  );

  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire rdSetup = psel && !penable && !pwrite;
  wire selIntCtl = paddr == CIC_OFF_INTCTL;
  wire selPFlag1 = paddr == CIC_OFF_PFLAG1;
  wire selPEn1 = paddr == CIC_OFF_PEN1;
  wire selPrio = paddr == CIC_OFF_PRIO;
  wire selPortB = paddr == CIC_OFF_PORT_B_INPUT_READ;
  wire selT1 = paddr == CIC_OFF_T1CNT;
  wire selStat = paddr == CIC_OFF_ISTAT;
  wire selMask = paddr == CIC_OFF_IMASK;
  wire mapped = selIntCtl | selPFlag1 | selPEn1 | selPrio | selPortB | selT1 | selStat | selMask;
  wire [7:0] wByte = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  wire pScheme = prio_q[CIC_B_PSCHEME];
  wire t1HiPri = prio_q[CIC_B_T1_HIPRI];
  wire t1Run = prio_q[CIC_B_T1_RUN];

  cic_timer1 uTimer1 (
    .clk(clk),
    .rst(rst),
    .run(t1Run),
    .load(wrEn && selT1),
    .loadVal(pwdata[15:0]),
    .count_q(t1Count),
    .wrap(t1Wrap)
  );

  // mismatch against latched pins, port b read relatches
  wire rbMismatch = rbSync != portbLatch_q;
  wire portBRead = rdEn && selPortB;
  wire int0Rise = int0Sync && !int0Prev_q;

  wire t0Set = timer0Overflow;
  wire int0Set = int0Rise;
  wire rbSet = rbMismatch;
  wire intCtlWr = wrEn && selIntCtl;

  // flags set by hardware events and written by software, set wins over clear
  wire [7:0] intCtl_d = intCtlWr ? wByte : intCtl_q;
  wire [7:0] intCtlNext = {intCtl_d[7:3],
    intCtl_d[CIC_B_T0_FL] | t0Set,
    intCtl_d[CIC_B_INT0_FL] | int0Set,
    intCtl_d[CIC_B_RB_FL] | rbSet};

  wire pFlag1_d = (wrEn && selPFlag1 ? wByte[CIC_B_T1] : pFlag1_q) | t1Wrap;

  wire t0Act = intCtl_q[CIC_B_T0_EN] && intCtl_q[CIC_B_T0_FL];
  wire int0Act = intCtl_q[CIC_B_INT0_EN] && intCtl_q[CIC_B_INT0_FL];
  wire rbAct = intCtl_q[CIC_B_RB_EN] && intCtl_q[CIC_B_RB_FL];
  wire t1Act = pEn1_q && pFlag1_q;
  wire gateHi = intCtl_q[CIC_B_GATE_HI];
  wire gateLo = intCtl_q[CIC_B_GATE_LO];
  wire coreAct = t0Act | int0Act | rbAct;

  // master gate with priority scheme off
  // peripheral gate with priority scheme off
  wire legacyReq = gateHi && (coreAct || (gateLo && t1Act));
  // bit 7 gates high priority sources
  // bit 6 gates low priority peripheral sources
  wire hiReq = gateHi && (coreAct || (t1HiPri && t1Act));
  wire loReq = gateLo && !t1HiPri && t1Act;

  // request needs flag, enable and open gate
  assign irqHigh = pScheme ? hiReq : legacyReq;
  assign irqLow = pScheme && loReq;

  wire [CIC_NEVT-1:0] evt = {t1Wrap, rbSet, int0Set, t0Set, 1'b0} | {4'h0, irqHigh | irqLow};
  wire [CIC_NEVT-1:0] statClr = (wrEn && selStat) ? pwdata[CIC_NEVT-1:0] : '0;
  wire [CIC_NEVT-1:0] iStat_d = (iStat_q & ~statClr) | evt;
  assign irq = |(iStat_q & iMask_q);

  wire [31:0] rdMux = selIntCtl ? {24'h0, intCtl_q} :
    selPFlag1 ? {31'h0, pFlag1_q} :
    selPEn1 ? {31'h0, pEn1_q} :
    selPrio ? {29'h0, prio_q} :
    selPortB ? {28'h0, rbSync} :
    selT1 ? {16'h0, t1Count} :
    selStat ? {27'h0, iStat_q} :
    selMask ? {27'h0, iMask_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      intCtl_q <= CIC_RST_INTCTL;
      pFlag1_q <= 1'b0;
      pEn1_q <= 1'b0;
      prio_q <= 3'h0;
      iStat_q <= '0;
      iMask_q <= '0;
      int0Prev_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      intCtl_q <= intCtlNext;
      pFlag1_q <= pFlag1_d;
      if (wrEn && selPEn1) pEn1_q <= wByte[CIC_B_T1];
      if (wrEn && selPrio) prio_q <= wByte[2:0];
      if (wrEn && selMask) iMask_q <= pwdata[CIC_NEVT-1:0];
      iStat_q <= iStat_d;
      int0Prev_q <= int0Sync;
      if (rdSetup) prdata_q <= rdMux;
    end
  end

  // a port b read ends the mismatch
  always_ff @(posedge clk) begin
    if (rst) begin
      portbLatch_q <= 4'h0;
    end else if (portBRead) begin
      portbLatch_q <= rbSync;
    end
  end

  sequence s_t1_wrap;
    t1Wrap;
  endsequence
  sequence s_flag_up;
    pFlag1_q;
  endsequence

  a_gie_blocks_all: assert property (@(posedge clk) disable iff (rst)
    !pScheme && !gateHi |-> !irqHigh && !irqLow)
    else $error("interrupt passed closed master gate");
  a_hi_gate_only: assert property (@(posedge clk) disable iff (rst)
    pScheme && !gateHi |-> !irqHigh)
    else $error("high priority passed closed gate");
  a_periph_gate: assert property (@(posedge clk) disable iff (rst)
    !pScheme && !gateLo && !coreAct |-> !irqHigh)
    else $error("peripheral passed closed gate");
  a_low_gate: assert property (@(posedge clk) disable iff (rst)
    pScheme && !gateLo |-> !irqLow)
    else $error("low priority passed closed gate");
  a_flag_polls: assert property (@(posedge clk) disable iff (rst)
    timer0Overflow |=> intCtl_q[CIC_B_T0_FL])
    else $error("flag not set by event");
  a_t0_sticky: assert property (@(posedge clk) disable iff (rst)
    intCtl_q[CIC_B_T0_FL] && !intCtlWr |=> intCtl_q[CIC_B_T0_FL])
    else $error("timer0 flag dropped without write");
  a_int0_sets: assert property (@(posedge clk) disable iff (rst)
    int0Rise |=> intCtl_q[CIC_B_INT0_FL])
    else $error("int0 flag not set");
  a_rb_mismatch: assert property (@(posedge clk) disable iff (rst)
    rbMismatch |=> intCtl_q[CIC_B_RB_FL])
    else $error("port b change flag not set");
  a_rb_read_ends: assert property (@(posedge clk) disable iff (rst)
    portBRead |=> portbLatch_q == $past(rbSync))
    else $error("port b read did not relatch");
  a_t1_latch: assert property (@(posedge clk) disable iff (rst)
    s_t1_wrap |=> s_flag_up)
    else $error("timer1 flag not latched");
  a_t1_enable: assert property (@(posedge clk) disable iff (rst)
    !pEn1_q && !coreAct |-> !irqHigh && !irqLow)
    else $error("timer1 raised while disabled");
  a_req_cause: assert property (@(posedge clk) disable iff (rst)
    irqHigh |-> gateHi && (coreAct || t1Act))
    else $error("request without enabled flag");
endmodule

/* File: cic_irq_partner.sv */
// processor-side model that picks a vector from the request lines
module cic_irq_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic irqHigh,
  input wire logic irqLow,
  output logic [1:0] vec_q
);
  // high request wins over low
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_q <= 2'h0;
    end else begin
      vec_q <= irqHigh ? 2'h1 : (irqLow ? 2'h2 : 2'h0);
    end
  end
endmodule

/* File: cic_pkg.sv */
// package: register map, field positions and reset values for the core interrupt control block
package cic_pkg;
  localparam logic [11:0] CIC_OFF_INTCTL = 12'h000;
  localparam logic [11:0] CIC_OFF_PFLAG1 = 12'h004;
  localparam logic [11:0] CIC_OFF_PEN1 = 12'h008;
  localparam logic [11:0] CIC_OFF_PRIO = 12'h00c;
  localparam logic [11:0] CIC_OFF_PORT_B_INPUT_READ = 12'h010;
  localparam logic [11:0] CIC_OFF_T1CNT = 12'h014;
  localparam logic [11:0] CIC_OFF_ISTAT = 12'h018;
  localparam logic [11:0] CIC_OFF_IMASK = 12'h01c;
  localparam int CIC_B_GATE_HI = 7;
  localparam int CIC_B_GATE_LO = 6;
  localparam int CIC_B_T0_EN = 5;
  localparam int CIC_B_INT0_EN = 4;
  localparam int CIC_B_RB_EN = 3;
  localparam int CIC_B_T0_FL = 2;
  localparam int CIC_B_INT0_FL = 1;
  localparam int CIC_B_RB_FL = 0;
  localparam int CIC_B_T1 = 0;
  localparam int CIC_B_PSCHEME = 0;
  localparam int CIC_B_T1_HIPRI = 1;
  localparam int CIC_B_T1_RUN = 2;
  localparam logic [7:0] CIC_RST_INTCTL = 8'h00;
  localparam logic [7:0] CIC_RST_BYTE = 8'h00;
  localparam logic [15:0] CIC_T1_MAX = 16'hffff;
  localparam logic [15:0] CIC_T1_RST = 16'h0000;
  localparam int CIC_NEVT = 5;
endpackage

/* File: cic_sync.sv */
// two-flop synchroniser for pin inputs
module cic_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  if (W < 1) begin : g_width_check
    $error("width must be positive");
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: cic_timer1.sv */
// 16-bit up counter with wrap pulse and software load
module cic_timer1 (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] loadVal,
  output logic [15:0] count_q,
  output logic wrap
);
  import cic_pkg::*;
  assign wrap = run && !load && (count_q == CIC_T1_MAX);
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= CIC_T1_RST;
    end else if (load) begin
      count_q <= loadVal;
    end else if (run) begin
      count_q <= count_q + 16'h0001;
    end
  end
  a_wrap_to_zero: assert property (@(posedge clk) disable iff (rst)
    wrap |=> count_q == CIC_T1_RST)
    else $error("timer1 did not wrap to zero");
endmodule

/* File: core_interrupt_control_bench.sv */
// self-checking bench for the core interrupt control block
module core_interrupt_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cic_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic err;} cic_row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irqHigh, irqLow, irq, e;
  logic timer0Overflow, extInt0Pin;
  logic [3:0] upperPortBPins;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] vec;
  int n_mismatch = 0;
  int check_count = 0;
  cic_row_t rows [11] = '{'{CIC_OFF_INTCTL, 32'hf8, 32'hf8, 1'b0}, '{CIC_OFF_INTCTL, 32'h0, 32'h0, 1'b0},
    '{CIC_OFF_PEN1, 32'h1, 32'h1, 1'b0}, '{CIC_OFF_PEN1, 32'h0, 32'h0, 1'b0},
    '{CIC_OFF_IMASK, 32'h1f, 32'h1f, 1'b0}, '{CIC_OFF_IMASK, 32'h0, 32'h0, 1'b0},
    '{CIC_OFF_T1CNT, 32'h1234, 32'h1234, 1'b0}, '{CIC_OFF_PRIO, 32'h3, 32'h3, 1'b0},
    '{CIC_OFF_PRIO, 32'h0, 32'h0, 1'b0}, '{CIC_OFF_ISTAT, 32'h1f, 32'h0, 1'b0},
    '{12'h020, 32'hff, 32'h0, 1'b1}};

  cic_core cic_core_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0Overflow(timer0Overflow), .extInt0Pin(extInt0Pin), .upperPortBPins(upperPortBPins),
    .irqHigh(irqHigh), .irqLow(irqLow), .irq(irq));
  cic_irq_partner cic_irq_partner_inst (.clk(clk), .rst(rst), .irqHigh(irqHigh), .irqLow(irqLow),
    .vec_q(vec));

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic ck3(input logic [2:0] x);
    @(negedge clk);
    chk({29'h0, irq, irqLow, irqHigh}, {29'h0, x});
  endtask
  // one apb transfer; read data taken at the access edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_mismatch++;
    e = pslverr;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(r, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #50000;
    n_mismatch++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, timer0Overflow, extInt0Pin} = 5'h0;
    {upperPortBPins, paddr, pwdata} = 48'h0;
    cyc(12);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(12'(i * 4), 32'h0);
    ck3(3'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].x);
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    @(posedge clk) timer0Overflow <= 1'b1;
    @(posedge clk) timer0Overflow <= 1'b0;
    rd(CIC_OFF_INTCTL, 32'h04);
    ck3(3'h0);
    wr(CIC_OFF_INTCTL, 32'ha4);
    ck3(3'h1);
    wr(CIC_OFF_INTCTL, 32'h24);
    ck3(3'h0);
    wr(CIC_OFF_INTCTL, 32'h0);
    rd(CIC_OFF_INTCTL, 32'h0);
    @(posedge clk) extInt0Pin <= 1'b1;
    cyc(6);
    rd(CIC_OFF_INTCTL, 32'h02);
    cyc(4);
    rd(CIC_OFF_INTCTL, 32'h02);
    wr(CIC_OFF_INTCTL, 32'h0);
    upperPortBPins <= 4'h5;
    cyc(5);
    rd(CIC_OFF_INTCTL, 32'h01);
    wr(CIC_OFF_INTCTL, 32'h0);
    rd(CIC_OFF_INTCTL, 32'h01);
    rd(CIC_OFF_PORT_B_INPUT_READ, 32'h5);
    wr(CIC_OFF_INTCTL, 32'h0);
    rd(CIC_OFF_INTCTL, 32'h0);
    wr(CIC_OFF_T1CNT, 32'hfff0);
    wr(CIC_OFF_PRIO, 32'h4);
    cyc(20);
    wr(CIC_OFF_PRIO, 32'h0);
    rd(CIC_OFF_PFLAG1, 32'h1);
    apb(CIC_OFF_T1CNT, 1'b0, 32'h0);
    chk({16'h0, r[15:0]}, 32'h7);
    wr(CIC_OFF_PEN1, 32'h1);
    wr(CIC_OFF_INTCTL, 32'h80);
    ck3(3'h0);
    wr(CIC_OFF_INTCTL, 32'hc0);
    ck3(3'h1);
    wr(CIC_OFF_PEN1, 32'h0);
    ck3(3'h0);
    wr(CIC_OFF_PEN1, 32'h1);
    wr(CIC_OFF_PRIO, 32'h1);
    wr(CIC_OFF_INTCTL, 32'h40);
    ck3(3'h2);
    @(negedge clk);
    chk({30'h0, vec}, 32'h2);
    wr(CIC_OFF_INTCTL, 32'h80);
    ck3(3'h0);
    wr(CIC_OFF_PRIO, 32'h3);
    ck3(3'h1);
    wr(CIC_OFF_INTCTL, 32'h40);
    ck3(3'h0);
    wr(CIC_OFF_INTCTL, 32'h80);
    wr(CIC_OFF_IMASK, 32'h10);
    ck3(3'h5);
    wr(CIC_OFF_ISTAT, 32'h10);
    ck3(3'h1);
    @(posedge clk) rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rd(CIC_OFF_PEN1, 32'h0);
    ck3(3'h0);
    close_out();
  end
endmodule
